// ### inc/fpg_pkg.sv
// Package for the flash program/erase access guard.
// Assumes a single 100 MHz system clock; all users reference names as fpg_pkg::name.
package fpg_pkg;
	localparam int ADDR_W = 24;
	localparam logic [7:0] KEY_DOWNLOAD = 8'ha5;
	localparam logic [7:0] KEY_PROGRAM = 8'h5a;
	localparam logic [7:0] KEY_CLEAR = 8'h00;
	localparam logic [ADDR_W-1:0] RAM_BASE = 24'hffb000;
	localparam logic [ADDR_W-1:0] RAM_LAST = 24'hffefff;
	localparam logic [ADDR_W-1:0] FLASH_BASE = 24'h000000;
	localparam logic [ADDR_W-1:0] FLASH_LAST = 24'h07ffff;
	localparam logic [ADDR_W-1:0] ROUTINE_BYTES = 24'h001000;
	localparam int STACK_BYTES = 128;
	localparam int DOWNLOAD_CYCLES = 16;
	localparam int OP_CYCLES = 64;
	localparam logic [1:0] BANK_USER = 2'h0;
	localparam logic [1:0] BANK_BOOT = 2'h1;
	localparam logic [1:0] BANK_EMBEDDED = 2'h2;
	localparam int RESET_HOLD_NS = 100000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {ST_IDLE, ST_DOWNLOAD, ST_READY, ST_BUSY, ST_DONE} fpg_state_t;
endpackage

// ### verilog/fpg_ticker.sv
// Cycle counter used to time download and operation phases.
// Assumes start is a one-cycle pulse from logic on sys_clk.
`timescale 1ns/10ps
module fpg_ticker (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [7:0] length,
	output logic done
);
	logic [7:0] count;
	logic [7:0] next_count;
	logic next_done;

	// Count down from length; done pulses on the final count.
	always_comb
	begin
		next_count = count;
		next_done = 1'b0;
		if (start)
			next_count = length;
		else if (count != 8'h00)
		begin
			next_count = count - 8'h01;
			next_done = (count == 8'h01);
		end
	end

	// Registers only.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			count <= 8'h00;
			done <= 1'b0;
		end
		else
		begin
			count <= next_count;
			done <= next_done;
		end
	end
endmodule // fpg_ticker

// ### verilog/fpg_guard.sv
// Flash program/erase access guard: download, key gating, flash access blocking.
// Assumes the CPU runs procedure code from RAM and drives the plain control ports.
`timescale 1ns/10ps
module fpg_guard (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic key_wr,
	input wire logic [7:0] key_wdata,
	input wire logic dest_wr,
	input wire logic [23:0] dest_wdata,
	input wire logic download_start_bit,
	input wire logic bank_wr,
	input wire logic [1:0] bank_wdata,
	input wire logic op_start,
	input wire logic [23:0] program_data_addr_param,
	output logic [7:0] flash_unlock_key_reg,
	output logic [23:0] download_dest_addr_reg,
	output logic [1:0] flash_array_bank,
	output logic flash_access_en,
	output logic download_busy,
	output logic download_ok,
	output logic download_err,
	output logic op_busy,
	output logic program_err,
	output logic [23:0] ram_occupied_lo,
	output logic [23:0] ram_occupied_hi
);
	fpg_pkg::fpg_state_t state;
	fpg_pkg::fpg_state_t next_state;
	logic [7:0] next_key;
	logic [23:0] next_dest;
	logic [1:0] next_bank;
	logic [1:0] saved_bank;
	logic [1:0] next_saved_bank;
	logic next_access;
	logic next_dl_busy;
	logic next_dl_ok;
	logic next_dl_err;
	logic next_op_busy;
	logic next_prog_err;
	logic [23:0] next_occ_lo;
	logic [23:0] next_occ_hi;
	logic tick_start;
	logic [7:0] tick_len;
	logic tick_done;
	logic data_in_flash;
	logic dest_in_ram;

	fpg_ticker u_ticker (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.start(tick_start),
		.length(tick_len),
		.done(tick_done)
	);

	// Address checks on the program data pointer and the download destination.
	assign data_in_flash = (program_data_addr_param >= fpg_pkg::FLASH_BASE) &&
		(program_data_addr_param <= fpg_pkg::FLASH_LAST);
	assign dest_in_ram = (download_dest_addr_reg >= fpg_pkg::RAM_BASE) &&
		(download_dest_addr_reg <= fpg_pkg::RAM_LAST - fpg_pkg::ROUTINE_BYTES + 24'h000001);

	// Sequencer: key gating, download, operation, access blocking.
	always_comb
	begin
		next_state = state;
		next_key = flash_unlock_key_reg;
		next_dest = download_dest_addr_reg;
		next_bank = flash_array_bank;
		next_saved_bank = saved_bank;
		next_access = flash_access_en;
		next_dl_busy = download_busy;
		next_dl_ok = download_ok;
		next_dl_err = download_err;
		next_op_busy = op_busy;
		next_prog_err = program_err;
		next_occ_lo = ram_occupied_lo;
		next_occ_hi = ram_occupied_hi;
		tick_start = 1'b0;
		tick_len = 8'h00;
		if (key_wr && state != fpg_pkg::ST_BUSY)
			next_key = key_wdata;
		unique case (state)
			fpg_pkg::ST_IDLE, fpg_pkg::ST_READY, fpg_pkg::ST_DONE:
			begin
				if (dest_wr)
					next_dest = dest_wdata;
				// Software bank writes are recorded here; the guard itself selects the embedded bank for a download and restores the saved one after it.
				if (bank_wr)
					next_bank = bank_wdata;
				if (state == fpg_pkg::ST_DONE && flash_unlock_key_reg == fpg_pkg::KEY_CLEAR)
					next_state = fpg_pkg::ST_IDLE;
				if (download_start_bit && flash_unlock_key_reg == fpg_pkg::KEY_DOWNLOAD)
				begin
					next_saved_bank = flash_array_bank;
					next_bank = fpg_pkg::BANK_EMBEDDED;
					next_dl_busy = 1'b1;
					next_dl_ok = 1'b0;
					next_dl_err = 1'b0;
					tick_start = 1'b1;
					tick_len = 8'(fpg_pkg::DOWNLOAD_CYCLES);
					next_state = fpg_pkg::ST_DOWNLOAD;
				end
				else if (op_start && state == fpg_pkg::ST_READY)
				begin
					if (flash_unlock_key_reg != fpg_pkg::KEY_PROGRAM || data_in_flash)
						next_prog_err = 1'b1;
					else
					begin
						next_prog_err = 1'b0;
						next_access = 1'b0;
						next_op_busy = 1'b1;
						tick_start = 1'b1;
						tick_len = 8'(fpg_pkg::OP_CYCLES);
						next_state = fpg_pkg::ST_BUSY;
					end
				end
			end
			fpg_pkg::ST_DOWNLOAD:
			begin
				// Flash stays readable here; only the program operation (ST_BUSY) closes the access window.
				if (tick_done)
				begin
					next_bank = saved_bank;
					next_dl_busy = 1'b0;
					next_dl_ok = dest_in_ram;
					next_dl_err = !dest_in_ram;
					next_occ_lo = download_dest_addr_reg;
					next_occ_hi = download_dest_addr_reg + fpg_pkg::ROUTINE_BYTES - 24'h000001;
					next_state = dest_in_ram ? fpg_pkg::ST_READY : fpg_pkg::ST_IDLE;
				end
			end
			fpg_pkg::ST_BUSY:
			begin
				if (tick_done)
				begin
					next_op_busy = 1'b0;
					next_access = 1'b1;
					next_state = fpg_pkg::ST_DONE;
				end
			end
		endcase
	end

	// State registers.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state <= fpg_pkg::ST_IDLE;
			flash_unlock_key_reg <= fpg_pkg::KEY_CLEAR;
			download_dest_addr_reg <= fpg_pkg::RAM_BASE;
			flash_array_bank <= fpg_pkg::BANK_USER;
			saved_bank <= fpg_pkg::BANK_USER;
			flash_access_en <= 1'b1;
			download_busy <= 1'b0;
			download_ok <= 1'b0;
			download_err <= 1'b0;
			op_busy <= 1'b0;
			program_err <= 1'b0;
			ram_occupied_lo <= 24'h000000;
			ram_occupied_hi <= 24'h000000;
		end
		else
		begin
			state <= next_state;
			flash_unlock_key_reg <= next_key;
			download_dest_addr_reg <= next_dest;
			flash_array_bank <= next_bank;
			saved_bank <= next_saved_bank;
			flash_access_en <= next_access;
			download_busy <= next_dl_busy;
			download_ok <= next_dl_ok;
			download_err <= next_dl_err;
			op_busy <= next_op_busy;
			program_err <= next_prog_err;
			ram_occupied_lo <= next_occ_lo;
			ram_occupied_hi <= next_occ_hi;
		end
	end

	sequence dl_req_s;
		download_start_bit && flash_unlock_key_reg == fpg_pkg::KEY_DOWNLOAD &&
			(state == fpg_pkg::ST_IDLE || state == fpg_pkg::ST_READY || state == fpg_pkg::ST_DONE);
	endsequence

	bank_switch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		dl_req_s |=> flash_array_bank == fpg_pkg::BANK_EMBEDDED)
		else $error("bank not switched on download");
	access_open_dl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		download_busy |-> flash_access_en)
		else $error("flash blocked during download");
	access_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_busy |-> !flash_access_en)
		else $error("flash open during operation");
	// Helper for the download length check: counts the cycles that the busy flag has stood.
	// A counter keeps the check cheap where a long repetition would be unrolled by the tools.
	logic [7:0] dl_len;
	logic [7:0] next_dl_len;

	always_comb
	begin
		next_dl_len = download_busy ? dl_len + 8'h01 : 8'h00;
	end

	// Helper register only; it drives no output.
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			dl_len <= 8'h00;
		else
			dl_len <= next_dl_len;
	end

	dl_finish_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		dl_req_s |=> download_busy ##17 !download_busy)
		else $error("download length wrong");
	dl_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(download_busy) |-> dl_len == 8'(fpg_pkg::DOWNLOAD_CYCLES + 1))
		else $error("download busy count wrong");
	occupied_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(download_ok) |-> ram_occupied_lo == download_dest_addr_reg)
		else $error("occupied region wrong");
	flash_data_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(state == fpg_pkg::ST_READY && op_start && !download_start_bit && data_in_flash) |=> program_err)
		else $error("flash data pointer not flagged");
	op_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(op_busy) |-> ##[60:66] !op_busy)
		else $error("operation length wrong");
	key_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_busy |=> $stable(flash_unlock_key_reg))
		else $error("key changed during operation");
endmodule // fpg_guard

// ### tb/fpg_cpu.sv
// Model of the CPU that runs the flash procedure code out of on-chip RAM.
// Assumes the guard samples every strobe on the rising edge of sys_clk.
`timescale 1ns/10ps
module fpg_cpu (
	input wire logic sys_clk,
	output logic key_wr,
	output logic [7:0] key_wdata,
	output logic dest_wr,
	output logic [23:0] dest_wdata,
	output logic download_start_bit,
	output logic bank_wr,
	output logic [1:0] bank_wdata,
	output logic op_start,
	output logic [23:0] program_data_addr_param
);
	// Quiet bus at time zero; the data pointer already sits in RAM.
	initial
	begin
		{key_wr, dest_wr, download_start_bit, bank_wr, op_start} = 5'h0;
		{key_wdata, dest_wdata, bank_wdata} = 34'h0;
		program_data_addr_param = fpg_pkg::RAM_BASE;
	end

	// One request per call: kind 0 key, 1 dest, 2 download, 3 operation, 4 bank select.
	// The code issuing these is taken to run from RAM with a 128-byte stack reserved.
	task automatic cmd(input logic [2:0] k, input logic [23:0] v);
		@(posedge sys_clk);
		key_wr <= (k == 3'h0);
		dest_wr <= (k == 3'h1);
		download_start_bit <= (k == 3'h2);
		op_start <= (k == 3'h3);
		bank_wr <= (k == 3'h4);
		{key_wdata, dest_wdata, bank_wdata} <= {v[7:0], v, v[1:0]};
		program_data_addr_param <= (k == 3'h3) ? v : program_data_addr_param;
		@(posedge sys_clk);
		{key_wr, dest_wr, download_start_bit, bank_wr, op_start} <= 5'h0;
		// Released data lines show the inverse so a stale value is never mistaken for live data.
		{key_wdata, dest_wdata, bank_wdata} <= ~{v[7:0], v, v[1:0]};
	endtask
endmodule // fpg_cpu

// ### tb/fpg_guard_tb.sv
// Self-checking bench for the flash program/erase access guard.
// Assumes the CPU model drives all control ports and sys_rst is synchronous.
`timescale 1ns/10ps
module fpg_guard_tb;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic key_wr, dest_wr, download_start_bit, bank_wr, op_start;
	logic [7:0] key_wdata, flash_unlock_key_reg;
	logic [23:0] dest_wdata, program_data_addr_param, download_dest_addr_reg, ram_occupied_lo, ram_occupied_hi;
	logic [1:0] bank_wdata, flash_array_bank;
	logic flash_access_en, download_busy, download_ok, download_err, op_busy, program_err;
	int miscompares = 0;
	int n_tests = 0;

	fpg_guard i_fpg_guard (.sys_clk, .sys_rst, .key_wr, .key_wdata, .dest_wr, .dest_wdata, .download_start_bit,
		.bank_wr, .bank_wdata, .op_start, .program_data_addr_param, .flash_unlock_key_reg, .download_dest_addr_reg,
		.flash_array_bank, .flash_access_en, .download_busy, .download_ok, .download_err, .op_busy, .program_err,
		.ram_occupied_lo, .ram_occupied_hi);
	fpg_cpu i_fpg_cpu (.sys_clk, .key_wr, .key_wdata, .dest_wr, .dest_wdata, .download_start_bit, .bank_wr,
		.bank_wdata, .op_start, .program_data_addr_param);

	// Free-running 100 MHz clock.
	always #5 sys_clk = ~sys_clk;

	// Compare one observed value against its expectation.
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Let the next edge land, then sample settled outputs.
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask

	// Bounded wait for both busy flags to drop; a hang ends the run.
	task automatic wait_idle();
		for (int i = 0; i < 300; i++)
		begin
			step();
			if (download_busy === 1'b0 && op_busy === 1'b0)
				return;
		end
		miscompares++;
		$display("CHECK FAILED at %0t: busy never dropped", $time);
		report_and_stop();
	endtask

	// Main sequence; reset is never raised while an operation runs.
	initial
	begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		step();
		chk(flash_unlock_key_reg, fpg_pkg::KEY_CLEAR);
		chk(download_dest_addr_reg, fpg_pkg::RAM_BASE);
		chk({flash_array_bank, flash_access_en, download_busy, op_busy}, 5'h04);
		$display("test reset values done");
		// A download without the unlock key must be ignored.
		i_fpg_cpu.cmd(3'h2, 24'h0);
		step();
		chk({flash_array_bank, download_busy}, 3'h0);
		$display("test download refused done");
		i_fpg_cpu.cmd(3'h0, 24'h0000a5);
		i_fpg_cpu.cmd(3'h1, 24'hffc000);
		i_fpg_cpu.cmd(3'h2, 24'h0);
		step();
		chk({flash_array_bank, download_busy}, 3'h5);
		chk(flash_access_en, 1'b1);
		wait_idle();
		chk({download_ok, download_err}, 2'h2);
		chk(flash_array_bank, fpg_pkg::BANK_USER);
		chk(ram_occupied_lo, 24'hffc000);
		chk(ram_occupied_hi, 24'hffcfff);
		$display("test download done");
		// Data pointer inside flash is refused even with the right key.
		i_fpg_cpu.cmd(3'h0, 24'h00005a);
		i_fpg_cpu.cmd(3'h3, 24'h000100);
		step();
		chk({program_err, op_busy}, 2'h2);
		i_fpg_cpu.cmd(3'h3, 24'hffd000);
		step();
		chk({op_busy, flash_access_en, program_err}, 3'h4);
		wait_idle();
		chk(flash_access_en, 1'b1);
		i_fpg_cpu.cmd(3'h3, 24'hffd000);
		step();
		chk(op_busy, 1'b0);
		i_fpg_cpu.cmd(3'h0, 24'h0);
		step();
		chk(flash_unlock_key_reg, fpg_pkg::KEY_CLEAR);
		$display("test program done");
		i_fpg_cpu.cmd(3'h4, 24'h1);
		step();
		chk(flash_array_bank, fpg_pkg::BANK_BOOT);
		i_fpg_cpu.cmd(3'h4, 24'h0);
		// With only the download key in place an operation must be refused with an error.
		i_fpg_cpu.cmd(3'h0, 24'h0000a5);
		i_fpg_cpu.cmd(3'h2, 24'h0);
		wait_idle();
		i_fpg_cpu.cmd(3'h3, 24'hffd000);
		step();
		chk({program_err, op_busy}, 2'h2);
		$display("test wrong key done");
		// Destination outside RAM must end the download in error.
		i_fpg_cpu.cmd(3'h1, 24'h001000);
		i_fpg_cpu.cmd(3'h2, 24'h0);
		wait_idle();
		chk({download_ok, download_err}, 2'h1);
		$display("test bank and bad destination done");
		// A reset after the operation is held for the long period; the status flags, bank, occupied base and destination return to reset values.
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (fpg_pkg::RESET_HOLD_CYCLES) @(posedge sys_clk);
		sys_rst <= 1'b0;
		step();
		chk({download_ok, download_err, program_err, flash_array_bank}, 5'h00);
		chk(ram_occupied_lo, 24'h000000);
		chk(download_dest_addr_reg, fpg_pkg::RAM_BASE);
		$display("test long reset done");
		report_and_stop();
	end
endmodule // fpg_guard_tb
